// File: inc/isvu_defs.svh
// Offsets, field positions, reset values and vector addresses of the vector unit
`ifndef ISVU_DEFS_SVH
`define ISVU_DEFS_SVH

// Register offsets
`define OFF_CTRL      8'h00
`define OFF_VBASE     8'h04
`define OFF_AM_ADDR   8'h08
`define OFF_REQ       8'h0C
`define OFF_PRIO0     8'h10
`define OFF_PRIO1     8'h14
`define OFF_PRIO2     8'h18
`define OFF_STATUS    8'h1C
`define OFF_SPEND     8'h20

// Control register fields
`define CTRL_I_BIT    0
`define CTRL_D_BIT    1
`define CTRL_U_BIT    2
`define CTRL_IPL_LO   4
`define CTRL_AM_BIT   8
`define CTRL_POL_LO   9

// Status register fields
`define STAT_SRC_LO   24
`define STAT_BUSY_BIT 31

// Reset values
`define RST_IPL       3'h0
`define RST_VBASE     20'h00000
`define RST_AM_ADDR   20'h00000
`define RST_PRIO      3'h0
`define RST_POL       3'h0

// Source counts
`define N_PERIPH      22
`define N_PINS        5
`define FIRST_PERIPH_NUM 10
`define SW_SHARED_MAX 6'h1F

// Fixed vector table
`define VEC_UND       20'hFFFDC
`define VEC_OVF       20'hFFFE0
`define VEC_BRK       20'hFFFE4
`define VEC_AMATCH    20'hFFFE8
`define VEC_STEP      20'hFFFEC
`define VEC_WDT       20'hFFFF0
`define VEC_DBC       20'hFFFF4
`define VEC_NMI       20'hFFFF8
`define VEC_RESET     20'hFFFFC
`define BRK_REDIRECT  8'hFF

`endif

// File: inc/isvu_pkg.sv
// Types of the interrupt source and vector unit
package isvu_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_DATA = 3'b100
  } fsm_t;

  typedef enum logic [3:0] {
    SRC_RESET  = 4'h0,
    SRC_NMI    = 4'h1,
    SRC_DBC    = 4'h2,
    SRC_WDT    = 4'h3,
    SRC_UND    = 4'h4,
    SRC_OVF    = 4'h5,
    SRC_BRK    = 4'h6,
    SRC_SWINT  = 4'h7,
    SRC_AMATCH = 4'h8,
    SRC_STEP   = 4'h9,
    SRC_PERIPH = 4'hA
  } src_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

  typedef struct packed {
    fsm_t state;
    logic i_flag;
    logic d_flag;
    logic u_flag;
    logic u_saved;
    logic u_saved_v;
    logic [2:0] processor_priority_floor;
    logic am_en;
    logic [2:0] edge_pol;
    logic [19:0] vbase;
    logic [19:0] am_addr;
    logic [21:0] req;
    logic [65:0] prio;
    logic sp_rst;
    logic sp_nmi;
    logic sp_dbc;
    logic sp_wdt;
    logic sp_und;
    logic sp_ovf;
    logic sp_brk;
    logic sp_sw;
    logic sp_am;
    logic sp_step;
    logic [5:0] sw_num;
    src_t cur_src;
    logic [5:0] cur_num;
    logic brk_var;
    logic [31:0] rdata;
    logic mem_rd;
    logic [19:0] mem_addr;
    logic branch;
    logic [19:0] branch_addr;
  } unit_state_t;

endpackage : isvu_pkg

// File: hw/edge_sync.sv
// Pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Pin
  input wire logic pin_i,
  // Synchronised level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  isvu_pkg::sync_state_t st_r;
  isvu_pkg::sync_state_t st_nxt;

  always_comb begin
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  // Pins idle high after reset so no false edge is seen
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r <= 3'h7;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.s2;
  assign rise_o = st_r.s2 & ~st_r.s3;
  assign fall_o = ~st_r.s2 & st_r.s3;

endmodule : edge_sync

`default_nettype wire

// File: hw/interrupt_source_vector_unit.sv
// Interrupt source classification, arbitration and vector fetch
// How it works
// - Instruction traps ignore mask flag and priority
// - Illegal-op trap vectors through fixed undefined entry
// - Overflow trap fires only with overflow flag set
// - Break trap redirects to variable table on FF
// - Software numbers 0-63; 0-31 share peripheral vectors
// - Numbers 0-31 save, clear, restore stack flag
// - Numbers 32-63 leave stack flag untouched
// - Reset fetches start address from last entry
// - Low non-maskable pin vectors through its entry
// - Special events are non-maskable; watchdog entry fixed
// - Debug step flag raises step after instructions
// - Debugger break vectors through its fixed entry
// - Enabled address match fires before matched instruction
// - Match on non-first instruction byte never fires
// - Peripheral requests maskable, sharing software vectors 0-31
// - Mask flag and priority gate only maskable
// - Twenty-two peripheral request sources are provided
// - Low key wake pin raises key request
// - Edge inputs request on selected edge polarity
// - Fixed table four-byte entries from FFFDC upward
// - Accepted request fetches vector and branches
// - Variable table: base plus four per number
// - Accept when flag set, requested, level above floor
// - Hardware sets and clears request; software clears only
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "isvu_defs.svh"

module interrupt_source_vector_unit (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Instruction events from the core
  input wire logic illegal_op_trap_instruction_i,
  input wire logic overflow_trap_instruction_i,
  input wire logic overflow_flag_i,
  input wire logic break_trap_instruction_i,
  input wire logic swint_instruction_i,
  input wire logic [5:0] swint_num_i,
  input wire logic insn_done_i,
  input wire logic insn_start_i,
  input wire logic insn_first_byte_i,
  input wire logic [19:0] insn_addr_i,
  input wire logic reti_i,
  // Special hardware events
  input wire logic nmi_n_i,
  input wire logic watchdog_event_i,
  input wire logic debugger_break_event_i,
  // Peripheral requests: bus collision, DMA0-1, A-D, UART tx/rx, timers
  input wire logic [18:0] periph_req_i,
  input wire logic key_wake_pin_n_i,
  input wire logic [2:0] ext_edge_request_i,
  // Vector fetch to memory
  output logic mem_rd_o,
  output logic [19:0] mem_addr_o,
  input wire logic [31:0] mem_rdata_i,
  // Branch to routine
  output logic branch_o,
  output logic [19:0] branch_addr_o,
  output logic [3:0] branch_src_o,
  output logic [5:0] branch_num_o,
  output logic busy_o,
  output logic u_flag_o
);

  isvu_pkg::unit_state_t st_r;
  isvu_pkg::unit_state_t st_nxt;

  logic [4:0] pin_raw;
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;
  logic [21:0] hw_set;
  logic [21:0] clr_req;
  logic [4:0] best_idx;
  logic [2:0] best_lvl;
  logic best_v;
  logic [2:0] lvl;
  logic pick_v;
  isvu_pkg::src_t pick_src;
  logic [19:0] pick_vec;
  logic [5:0] pick_num;
  logic pick_swap_u;
  logic [31:0] rd_val;

  // Pins: 0 non-maskable, 1 key wake, 2..4 edge requests
  assign pin_raw = {ext_edge_request_i, key_wake_pin_n_i, nmi_n_i};

  genvar g;
  generate
    for (g = 0; g < `N_PINS; g++) begin : g_pin
      edge_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(pin_raw[g]),
        .level_o(pin_lvl[g]),
        .rise_o(pin_rise[g]),
        .fall_o(pin_fall[g])
      );
    end
  endgenerate

  // Request sources in software-number order starting at number 10
  always_comb begin
    hw_set[2:0] = periph_req_i[2:0];
    hw_set[3] = ~pin_lvl[1];
    hw_set[18:4] = periph_req_i[17:3];
    hw_set[21:19] = '0;
    for (int k = 0; k < 3; k++) begin
      hw_set[19 + k] = st_r.edge_pol[k] ? pin_rise[2 + k] : pin_fall[2 + k];
    end
    hw_set[18] = hw_set[18] | periph_req_i[18];
  end

  // Highest programmed level strictly above the floor wins
  always_comb begin
    best_idx = '0;
    best_lvl = st_r.processor_priority_floor;
    best_v = 1'b0;
    lvl = '0;
    for (int k = 0; k < `N_PERIPH; k++) begin
      lvl = st_r.prio[3 * k +: 3];
      if (st_r.req[k] && (lvl > best_lvl)) begin
        best_idx = 5'(k);
        best_lvl = lvl;
        best_v = 1'b1;
      end
    end
  end

  // Arbitration: non-maskable events first, then maskable requests
  always_comb begin
    pick_v = 1'b1;
    pick_src = isvu_pkg::SRC_PERIPH;
    pick_vec = '0;
    pick_num = '0;
    pick_swap_u = 1'b0;
    if (st_r.sp_rst) begin
      pick_src = isvu_pkg::SRC_RESET;
      pick_vec = `VEC_RESET;
    end else if (st_r.sp_nmi) begin
      pick_src = isvu_pkg::SRC_NMI;
      pick_vec = `VEC_NMI;
    end else if (st_r.sp_dbc) begin
      pick_src = isvu_pkg::SRC_DBC;
      pick_vec = `VEC_DBC;
    end else if (st_r.sp_wdt) begin
      pick_src = isvu_pkg::SRC_WDT;
      pick_vec = `VEC_WDT;
    end else if (st_r.sp_und) begin
      pick_src = isvu_pkg::SRC_UND;
      pick_vec = `VEC_UND;
    end else if (st_r.sp_ovf) begin
      pick_src = isvu_pkg::SRC_OVF;
      pick_vec = `VEC_OVF;
    end else if (st_r.sp_brk) begin
      pick_src = isvu_pkg::SRC_BRK;
      pick_vec = `VEC_BRK;
    end else if (st_r.sp_sw) begin
      pick_src = isvu_pkg::SRC_SWINT;
      pick_num = st_r.sw_num;
      pick_vec = st_r.vbase + {12'h000, st_r.sw_num, 2'b00};
      pick_swap_u = (st_r.sw_num <= `SW_SHARED_MAX);
    end else if (st_r.sp_am) begin
      pick_src = isvu_pkg::SRC_AMATCH;
      pick_vec = `VEC_AMATCH;
    end else if (st_r.sp_step) begin
      pick_src = isvu_pkg::SRC_STEP;
      pick_vec = `VEC_STEP;
    end else if (st_r.i_flag && best_v) begin
      pick_num = 6'(best_idx) + 6'(`FIRST_PERIPH_NUM);
      pick_vec = st_r.vbase + {12'h000, pick_num, 2'b00};
      pick_swap_u = 1'b1;
    end else begin
      pick_v = 1'b0;
    end
  end

  // Register read value
  always_comb begin
    rd_val = '0;
    unique case (reg_addr_i)
      `OFF_CTRL: begin
        rd_val[`CTRL_I_BIT] = st_r.i_flag;
        rd_val[`CTRL_D_BIT] = st_r.d_flag;
        rd_val[`CTRL_U_BIT] = st_r.u_flag;
        rd_val[`CTRL_IPL_LO +: 3] = st_r.processor_priority_floor;
        rd_val[`CTRL_AM_BIT] = st_r.am_en;
        rd_val[`CTRL_POL_LO +: 3] = st_r.edge_pol;
      end
      `OFF_VBASE: rd_val[19:0] = st_r.vbase;
      `OFF_AM_ADDR: rd_val[19:0] = st_r.am_addr;
      `OFF_REQ: rd_val[21:0] = st_r.req;
      `OFF_PRIO0, `OFF_PRIO1, `OFF_PRIO2: begin
        for (int j = 0; j < 8; j++) begin
          if ((8 * (reg_addr_i[3:2] - 2'h0) + j) < `N_PERIPH) begin
            rd_val[4 * j +: 3] = st_r.prio[3 * (8 * (reg_addr_i - `OFF_PRIO0) / 4 + j) +: 3];
          end
        end
      end
      `OFF_STATUS: begin
        rd_val[19:0] = st_r.branch_addr;
        rd_val[`STAT_SRC_LO +: 4] = st_r.cur_src;
        rd_val[`STAT_BUSY_BIT] = (st_r.state != isvu_pkg::ST_IDLE);
      end
      `OFF_SPEND: rd_val[9:0] = {st_r.sp_step, st_r.sp_am, st_r.sp_sw, st_r.sp_brk,
                                 st_r.sp_ovf, st_r.sp_und, st_r.sp_wdt, st_r.sp_dbc,
                                 st_r.sp_nmi, st_r.sp_rst};
      default: rd_val = '0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.mem_rd = 1'b0;
    st_nxt.branch = 1'b0;
    st_nxt.rdata = reg_rd_i ? rd_val : 32'h0000_0000;
    clr_req = '0;

    // Software writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `OFF_CTRL: begin
          st_nxt.i_flag = reg_wdata_i[`CTRL_I_BIT];
          st_nxt.d_flag = reg_wdata_i[`CTRL_D_BIT];
          st_nxt.u_flag = reg_wdata_i[`CTRL_U_BIT];
          st_nxt.processor_priority_floor = reg_wdata_i[`CTRL_IPL_LO +: 3];
          st_nxt.am_en = reg_wdata_i[`CTRL_AM_BIT];
          st_nxt.edge_pol = reg_wdata_i[`CTRL_POL_LO +: 3];
        end
        `OFF_VBASE: st_nxt.vbase = reg_wdata_i[19:0];
        `OFF_AM_ADDR: st_nxt.am_addr = reg_wdata_i[19:0];
        `OFF_REQ: clr_req = ~reg_wdata_i[21:0];
        `OFF_PRIO0, `OFF_PRIO1, `OFF_PRIO2: begin
          for (int j = 0; j < 8; j++) begin
            if ((8 * (reg_addr_i - `OFF_PRIO0) / 4 + j) < `N_PERIPH) begin
              st_nxt.prio[3 * (8 * (reg_addr_i - `OFF_PRIO0) / 4 + j) +: 3] =
                reg_wdata_i[4 * j +: 3];
            end
          end
        end
        default: ;
      endcase
    end

    // Return from a routine restores the stack select flag
    if (reti_i && st_r.u_saved_v) begin
      st_nxt.u_flag = st_r.u_saved;
      st_nxt.u_saved_v = 1'b0;
    end

    unique case (st_r.state)
      isvu_pkg::ST_IDLE: begin
        if (pick_v) begin
          st_nxt.state = isvu_pkg::ST_RD;
          st_nxt.mem_rd = 1'b1;
          st_nxt.mem_addr = pick_vec;
          st_nxt.cur_src = pick_src;
          st_nxt.cur_num = pick_num;
          st_nxt.brk_var = 1'b0;
          if (pick_swap_u) begin
            st_nxt.u_saved = st_nxt.u_flag;
            st_nxt.u_saved_v = 1'b1;
            st_nxt.u_flag = 1'b0;
          end
          unique case (pick_src)
            isvu_pkg::SRC_RESET: st_nxt.sp_rst = 1'b0;
            isvu_pkg::SRC_NMI: st_nxt.sp_nmi = 1'b0;
            isvu_pkg::SRC_DBC: st_nxt.sp_dbc = 1'b0;
            isvu_pkg::SRC_WDT: st_nxt.sp_wdt = 1'b0;
            isvu_pkg::SRC_UND: st_nxt.sp_und = 1'b0;
            isvu_pkg::SRC_OVF: st_nxt.sp_ovf = 1'b0;
            isvu_pkg::SRC_BRK: st_nxt.sp_brk = 1'b0;
            isvu_pkg::SRC_SWINT: st_nxt.sp_sw = 1'b0;
            isvu_pkg::SRC_AMATCH: st_nxt.sp_am = 1'b0;
            isvu_pkg::SRC_STEP: st_nxt.sp_step = 1'b0;
            default: clr_req[best_idx] = 1'b1;
          endcase
        end
      end
      isvu_pkg::ST_RD: st_nxt.state = isvu_pkg::ST_DATA;
      isvu_pkg::ST_DATA: begin
        if ((st_r.cur_src == isvu_pkg::SRC_BRK) && !st_r.brk_var &&
            (mem_rdata_i[7:0] == `BRK_REDIRECT)) begin
          st_nxt.state = isvu_pkg::ST_RD;
          st_nxt.mem_rd = 1'b1;
          st_nxt.mem_addr = st_r.vbase;
          st_nxt.brk_var = 1'b1;
        end else begin
          st_nxt.state = isvu_pkg::ST_IDLE;
          st_nxt.branch = 1'b1;
          st_nxt.branch_addr = mem_rdata_i[19:0];
        end
      end
      default: st_nxt.state = isvu_pkg::ST_IDLE;
    endcase

    // Hardware sets after all clears so a same-cycle event is kept
    st_nxt.req = (st_nxt.req & ~clr_req) | hw_set;
    if (!pin_lvl[0] && pin_fall[0]) begin
      st_nxt.sp_nmi = 1'b1;
    end
    if (debugger_break_event_i) begin
      st_nxt.sp_dbc = 1'b1;
    end
    if (watchdog_event_i) begin
      st_nxt.sp_wdt = 1'b1;
    end
    if (illegal_op_trap_instruction_i) begin
      st_nxt.sp_und = 1'b1;
    end
    if (overflow_trap_instruction_i && overflow_flag_i) begin
      st_nxt.sp_ovf = 1'b1;
    end
    if (break_trap_instruction_i) begin
      st_nxt.sp_brk = 1'b1;
    end
    if (swint_instruction_i) begin
      st_nxt.sp_sw = 1'b1;
      st_nxt.sw_num = swint_num_i;
    end
    if (insn_start_i && insn_first_byte_i && st_r.am_en && (insn_addr_i == st_r.am_addr)) begin
      st_nxt.sp_am = 1'b1;
    end
    if (insn_done_i && st_r.d_flag) begin
      st_nxt.sp_step = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.state <= isvu_pkg::ST_IDLE;
      st_r.sp_rst <= 1'b1;
      st_r.processor_priority_floor <= `RST_IPL;
      st_r.vbase <= `RST_VBASE;
      st_r.am_addr <= `RST_AM_ADDR;
      st_r.edge_pol <= `RST_POL;
      st_r.cur_src <= isvu_pkg::SRC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign mem_rd_o = st_r.mem_rd;
  assign mem_addr_o = st_r.mem_addr;
  assign branch_o = st_r.branch;
  assign branch_addr_o = st_r.branch_addr;
  assign branch_src_o = st_r.cur_src;
  assign branch_num_o = st_r.cur_num;
  assign busy_o = (st_r.state != isvu_pkg::ST_IDLE);
  assign u_flag_o = st_r.u_flag;

endmodule : interrupt_source_vector_unit

`default_nettype wire

// File: testbench/vector_memory.sv
// Memory model answering the unit's vector fetches
`timescale 1ns/1ps
`default_nettype none
`include "isvu_defs.svh"

module vector_memory (
  // Clock
  input wire logic clk_sys_i,
  // Fetch port
  input wire logic rd_i,
  input wire logic [19:0] addr_i,
  // Break entry holds the redirect marker
  input wire logic brk_ff_i,
  output logic [31:0] data_o
);
  // Word stands only in the cycle after the read, then flips every cycle
  always_ff @(posedge clk_sys_i) begin
    if (rd_i && brk_ff_i && addr_i == `VEC_BRK) begin
      data_o <= 32'h000000FF;
    end else if (rd_i) begin
      data_o <= {12'h000, ~addr_i};
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule : vector_memory
`default_nettype wire

// File: testbench/interrupt_source_vector_unit_assertions.sv
// Port-level checks of the interrupt source and vector unit
`timescale 1ns/1ps
`default_nettype none
`include "isvu_defs.svh"

module isvu_checker (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Inputs watched
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic watchdog_event_i,
  input wire logic illegal_op_trap_instruction_i,
  input wire logic nmi_n_i,
  input wire logic [31:0] mem_rdata_i,
  // Outputs watched
  input wire logic [31:0] reg_rdata_o,
  input wire logic mem_rd_o,
  input wire logic [19:0] mem_addr_o,
  input wire logic branch_o,
  input wire logic [19:0] branch_addr_o,
  input wire logic [3:0] branch_src_o,
  input wire logic [5:0] branch_num_o,
  input wire logic busy_o,
  input wire logic u_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [19:0] prev_data_r;
  logic [19:0] fixed_vec;
  always_ff @(posedge clk_sys_i) begin
    prev_data_r <= mem_rdata_i[19:0];
  end
  // Fixed-table sources except break only; the rest compare with themselves
  always_comb begin
    case (branch_src_o)
      4'h0: fixed_vec = `VEC_RESET;
      4'h1: fixed_vec = `VEC_NMI;
      4'h2: fixed_vec = `VEC_DBC;
      4'h3: fixed_vec = `VEC_WDT;
      4'h4: fixed_vec = `VEC_UND;
      4'h5: fixed_vec = `VEC_OVF;
      4'h8: fixed_vec = `VEC_AMATCH;
      4'h9: fixed_vec = `VEC_STEP;
      default: fixed_vec = mem_addr_o;
    endcase
  end
  a_reset_fetch: assert property ($rose(rst_n_i) |=> mem_rd_o && mem_addr_o == `VEC_RESET)
    else $error("reset fetch missing");
  a_fetch_branch: assert property (mem_rd_o |-> ##2 (branch_o || mem_rd_o))
    else $error("no branch after fetch");
  a_branch_data: assert property (branch_o |-> branch_addr_o == prev_data_r)
    else $error("branch address differs from vector");
  a_busy_window: assert property (mem_rd_o |-> busy_o [*2] ##1 (branch_o != busy_o))
    else $error("busy window wrong");
  a_rdata_idle: assert property ((!reg_rd_i || reg_addr_i > 8'h20) |=> reg_rdata_o == 32'h0)
    else $error("read data not zero");
  a_fixed_vec: assert property (branch_o |-> mem_addr_o == fixed_vec)
    else $error("wrong fixed vector address");
  a_swint_stack: assert property (branch_o && branch_src_o == 4'h7 && !branch_num_o[5] |-> !u_flag_o)
    else $error("stack flag not cleared");
  a_wdt_served: assert property (watchdog_event_i |-> ##[1:30] branch_o && branch_src_o == 4'h3)
    else $error("watchdog not served");
  a_nmi_served: assert property ($fell(nmi_n_i) |-> ##[3:30] branch_o && branch_src_o == 4'h1)
    else $error("pin request not served");
  a_trap_served: assert property (illegal_op_trap_instruction_i |-> ##[2:30] branch_o && branch_src_o == 4'h4)
    else $error("illegal-op trap not served");
  c_periph: cover property (branch_o && branch_src_o == 4'hA);
  c_swint_high: cover property (branch_o && branch_src_o == 4'h7 && branch_num_o[5]);
  c_redirect: cover property (mem_rd_o ##2 mem_rd_o);
endmodule : isvu_checker
`default_nettype wire

// File: testbench/interrupt_source_vector_unit_test.sv
// Self-checking bench for the interrupt source and vector unit
`timescale 1ns/1ps
`default_nettype none
`include "isvu_defs.svh"

module interrupt_source_vector_unit_test;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [8:0] ev = 9'h000;
  logic overflow_flag_i = 1'b0;
  logic [5:0] swint_num_i = 6'h00;
  logic insn_first_byte_i = 1'b0;
  logic [19:0] insn_addr_i = 20'h00000;
  logic nmi_n_i = 1'b1;
  logic [18:0] periph_req_i = 19'h0;
  logic key_wake_pin_n_i = 1'b1;
  logic [2:0] ext_edge_request_i = 3'h7;
  logic brk_ff = 1'b0;
  wire logic illegal_op_trap_instruction_i = ev[0];
  wire logic overflow_trap_instruction_i = ev[1];
  wire logic break_trap_instruction_i = ev[2];
  wire logic watchdog_event_i = ev[3];
  wire logic debugger_break_event_i = ev[4];
  wire logic swint_instruction_i = ev[5];
  wire logic insn_done_i = ev[6];
  wire logic insn_start_i = ev[7];
  wire logic reti_i = ev[8];
  logic [31:0] reg_rdata_o;
  logic [31:0] mem_rdata_i;
  logic mem_rd_o;
  logic [19:0] mem_addr_o;
  logic branch_o;
  logic [19:0] branch_addr_o;
  logic [3:0] branch_src_o;
  logic [5:0] branch_num_o;
  logic busy_o;
  logic u_flag_o;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0001575C;
  logic [19:0] vb;
  logic [5:0] n;
  logic [3:0] fx_src [5] = '{4'h4, 4'h5, 4'h6, 4'h3, 4'h2};
  logic [19:0] fx_vec [5] = '{`VEC_UND, `VEC_OVF, `VEC_BRK, `VEC_WDT, `VEC_DBC};

  interrupt_source_vector_unit interrupt_source_vector_unit_i (
    .clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .illegal_op_trap_instruction_i, .overflow_trap_instruction_i, .overflow_flag_i,
    .break_trap_instruction_i, .swint_instruction_i, .swint_num_i, .insn_done_i,
    .insn_start_i, .insn_first_byte_i, .insn_addr_i, .reti_i, .nmi_n_i, .watchdog_event_i,
    .debugger_break_event_i, .periph_req_i, .key_wake_pin_n_i, .ext_edge_request_i,
    .mem_rd_o, .mem_addr_o, .mem_rdata_i, .branch_o, .branch_addr_o, .branch_src_o,
    .branch_num_o, .busy_o, .u_flag_o);
  vector_memory vector_memory_i (.clk_sys_i, .rd_i(mem_rd_o), .addr_i(mem_addr_o),
    .brk_ff_i(brk_ff), .data_o(mem_rdata_i));

  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      conclude();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Routine address the memory model returns for a variable-table number
  function automatic logic [19:0] var_vec(input logic [5:0] num);
    return ~(vb + {12'h000, num, 2'b00});
  endfunction : var_vec

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    check("read data", reg_rdata_o, exp);
    @(posedge clk_sys_i);
  endtask : rd_chk

  // Events, peripheral lines, key and edge pins drop together one edge later
  task automatic pulse(input logic [8:0] m);
    ev <= m;
    @(posedge clk_sys_i);
    ev <= 9'h000;
    periph_req_i <= 19'h0;
    key_wake_pin_n_i <= 1'b1;
    ext_edge_request_i <= 3'h7;
    @(posedge clk_sys_i);
  endtask : pulse

  task automatic expect_br(input logic [3:0] s, input logic [19:0] a, input logic [5:0] num);
    repeat (40) begin
      @(negedge clk_sys_i);
      if (branch_o === 1'b1) break;
    end
    check("branch", branch_o, 1'b1);
    check("addr", branch_addr_o, a);
    check("src", branch_src_o, s);
    check("num", branch_num_o, num);
    @(posedge clk_sys_i);
  endtask : expect_br

  task automatic expect_none(input int cnt);
    logic seen;
    seen = 1'b0;
    repeat (cnt) begin
      @(negedge clk_sys_i);
      if (branch_o === 1'b1) seen = 1'b1;
    end
    check("unexpected branch", seen, 1'b0);
    @(posedge clk_sys_i);
  endtask : expect_none

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    expect_br(4'h0, ~`VEC_RESET, 6'h00);
    rd_chk(8'h40, 32'h0);
    overflow_flag_i <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      pulse(9'h001 << k);
      expect_br(fx_src[k], ~fx_vec[k], 6'h00);
    end
    overflow_flag_i <= 1'b0;
    pulse(9'h002);
    expect_none(12);
    nmi_n_i <= 1'b0;
    expect_br(4'h1, ~`VEC_NMI, 6'h00);
    nmi_n_i <= 1'b1;
    $display("fixed sources done");
    seed = xs(seed);
    vb = seed[19:0];
    wr(`OFF_VBASE, {12'h000, vb});
    rd_chk(`OFF_VBASE, {12'h000, vb});
    brk_ff <= 1'b1;
    pulse(9'h004);
    expect_br(4'h6, ~vb, 6'h00);
    brk_ff <= 1'b0;
    wr(`OFF_CTRL, 32'h4);
    rd_chk(`OFF_CTRL, 32'h4);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      n = (k == 0) ? 6'h1F : (k == 1) ? 6'h20 : seed[5:0];
      swint_num_i <= n;
      pulse(9'h020);
      expect_br(4'h7, var_vec(n), n);
      check("stack flag", u_flag_o, n[5]);
      pulse(9'h100);
      check("stack flag restored", u_flag_o, 1'b1);
    end
    $display("software numbers done");
    wr(`OFF_CTRL, 32'h0);
    periph_req_i <= 19'h1;
    pulse(9'h000);
    expect_none(12);
    rd_chk(`OFF_REQ, 32'h1);
    wr(`OFF_REQ, 32'h2);
    rd_chk(`OFF_REQ, 32'h0);
    periph_req_i <= 19'h1;
    pulse(9'h000);
    wr(`OFF_CTRL, 32'h31);
    wr(`OFF_PRIO0, 32'h3);
    expect_none(12);
    wr(`OFF_PRIO0, 32'h5004);
    expect_br(4'hA, var_vec(6'h0A), 6'h0A);
    rd_chk(`OFF_REQ, 32'h0);
    rd_chk(`OFF_PRIO0, 32'h5004);
    key_wake_pin_n_i <= 1'b0;
    pulse(9'h000);
    expect_br(4'hA, ~(vb + 20'h34), 6'h0D);
    wr(`OFF_PRIO2, 32'h6000);
    ext_edge_request_i <= 3'h6;
    pulse(9'h000);
    expect_br(4'hA, ~(vb + 20'h74), 6'h1D);
    wr(`OFF_CTRL, 32'h231);
    ext_edge_request_i <= 3'h6;
    pulse(9'h000);
    expect_br(4'hA, ~(vb + 20'h74), 6'h1D);
    $display("peripheral requests done");
    periph_req_i <= 19'h1;
    pulse(9'h009);
    rd_chk(`OFF_SPEND, 32'h10);
    expect_br(4'h3, ~`VEC_WDT, 6'h00);
    expect_br(4'h4, ~`VEC_UND, 6'h00);
    expect_br(4'hA, ~(vb + 20'h28), 6'h0A);
    seed = xs(seed);
    wr(`OFF_AM_ADDR, {12'h000, seed[19:0]});
    wr(`OFF_CTRL, 32'h100);
    insn_addr_i <= seed[19:0];
    pulse(9'h080);
    expect_none(12);
    insn_first_byte_i <= 1'b1;
    pulse(9'h080);
    expect_br(4'h8, ~`VEC_AMATCH, 6'h00);
    wr(`OFF_CTRL, 32'h2);
    pulse(9'h040);
    expect_br(4'h9, ~`VEC_STEP, 6'h00);
    wr(`OFF_CTRL, 32'h0);
    rd_chk(`OFF_STATUS, {8'h09, 4'h0, ~`VEC_STEP});
    $display("debug events done");
    conclude();
  end
endmodule : interrupt_source_vector_unit_test

bind interrupt_source_vector_unit isvu_checker isvu_checker_i (
  .clk_sys_i, .rst_n_i, .reg_rd_i, .reg_addr_i, .watchdog_event_i,
  .illegal_op_trap_instruction_i, .nmi_n_i, .mem_rdata_i, .reg_rdata_o, .mem_rd_o,
  .mem_addr_o, .branch_o, .branch_addr_o, .branch_src_o, .branch_num_o, .busy_o, .u_flag_o);
`default_nettype wire
